/* File: core/dasu_regs.vh */
`ifndef DASU_REGS_VH
`define DASU_REGS_VH
// debug frame layout: 4KB each, byte address inside the frame
`define DASU_FRAME_AW        12
`define DASU_ROM_FRAME_BASE  32'hFFA00000
`define DASU_CPU_FRAME_BASE  32'hFFA01000
`define DASU_CPU_FRAME_END   32'hFFA01FFF
// rom table word indexes; byte address is four times the index
`define DASU_ROM_IDX_CPU     10'h000
`define DASU_ROM_IDX_RSV1    10'h001
`define DASU_ROM_IDX_RSV2    10'h002
`define DASU_ROM_IDX_RSV3    10'h003
`define DASU_ROM_IDX_END     10'h004
`define DASU_ROM_VAL_CPU     32'h00001003
`define DASU_ROM_VAL_RSV1    32'h00002002
`define DASU_ROM_VAL_RSV2    32'h00003002
`define DASU_ROM_VAL_RSV3    32'h00004003
`define DASU_ROM_VAL_END     32'h00000000
// security status word in the cpu debug frame
`define DASU_CPU_IDX_STATUS  10'h000
`define DASU_STAT_OPEN_BIT   0
`define DASU_STAT_ZERO_BIT   1
`define DASU_STAT_IR_LSB     4
// visible unlock code location in one-time-programmable memory
`define DASU_OTP_CODE_ADDR   32'hF0000000
`define DASU_CODE_W          128
// tap instruction codes
`define DASU_IR_W            4
`define DASU_IR_EXTEST       4'h0
`define DASU_IR_SAMPLE       4'h1
`define DASU_IR_DBG_TAP      4'h2
`define DASU_IR_IDCODE       4'h6
`define DASU_IR_UNLOCK       4'hB
`define DASU_IR_BYPASS       4'hF
`define DASU_IR_CAPTURE      4'h1
// tap controller states
`define DASU_TS_RESET        4'h0
`define DASU_TS_IDLE         4'h1
`define DASU_TS_SEL_DR       4'h2
`define DASU_TS_CAP_DR       4'h3
`define DASU_TS_SH_DR        4'h4
`define DASU_TS_EX1_DR       4'h5
`define DASU_TS_PAU_DR       4'h6
`define DASU_TS_EX2_DR       4'h7
`define DASU_TS_UPD_DR       4'h8
`define DASU_TS_SEL_IR       4'h9
`define DASU_TS_CAP_IR       4'hA
`define DASU_TS_SH_IR        4'hB
`define DASU_TS_EX1_IR       4'hC
`define DASU_TS_PAU_IR       4'hD
`define DASU_TS_EX2_IR       4'hE
`define DASU_TS_UPD_IR       4'hF
`endif

/* File: core/dasu_top.v */
// Behaviour
// - two 4KB frames; unimplemented read zero
// - rom table gives five fixed words
// - idcode register reports the IDCODE parameter value
// - xor code, merge tie-offs, exact compare
// - shipped visible code unlocks the device
// - code bits only clear; all-zero locks forever
// - instruction 1011 selects unlock scan register
// - unlock register cleared only by power-on
// - secured: only unlock chain and bypass are reachable
// - boundary data shifts tdi through cells to tdo
`timescale 1ns/1ps
`include "dasu_regs.vh"
module dasu_top #(
  parameter [31:0]  IDCODE       = 32'h00001001,  // arbitrary neutral identification value
  parameter [127:0] FACTORY_CODE = {4{32'hFFFFFFFF}},
  parameter [127:0] TIE_XOR      = {4{32'h5A5A5A5A}},
  parameter         BSC_LEN      = 8
) (
  input  wire                 core_clk,
  input  wire                 rst_n,
  input  wire                 power_on_reset_n,
  input  wire                 rom_frame_select,
  input  wire                 cpu_debug_frame_select,
  input  wire [11:0]          bus_addr,
  input  wire                 bus_rd,
  input  wire                 bus_wr,
  input  wire [31:0]          bus_wdata,
  output reg  [31:0]          bus_rdata,
  output reg                  bus_rvalid,
  input  wire [127:0]         otp_visible_code,
  input  wire                 tck,
  input  wire                 tms,
  input  wire                 tdi,
  output reg                  tdo,
  output reg                  tdo_oe,
  output wire                 dbg_tap_en,
  output wire                 dbg_tdi,
  input  wire                 dbg_tdo,
  input  wire [BSC_LEN-1:0]   bsc_pin_in,
  output reg  [BSC_LEN-1:0]   bsc_pin_out,
  output reg                  bsc_drive,
  output wire                 device_open
);
  // two-stage synchronisers for the jtag pins, third stage for tck edges
  reg [1:0] tck_sync_reg;
  reg [1:0] tms_sync_reg;
  reg [1:0] tdi_sync_reg;
  reg       tck_old_reg;
  wire      tck_rise = tck_sync_reg[1] & ~tck_old_reg;
  wire      tck_fall = ~tck_sync_reg[1] & tck_old_reg;
  wire      tms_s    = tms_sync_reg[1];
  wire      tdi_s    = tdi_sync_reg[1];

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_sync_reg <= 2'h0;
      tms_sync_reg <= 2'h3;
      tdi_sync_reg <= 2'h0;
      tck_old_reg  <= 1'b0;
    end else begin
      tck_sync_reg <= {tck_sync_reg[0], tck};
      tms_sync_reg <= {tms_sync_reg[0], tms};
      tdi_sync_reg <= {tdi_sync_reg[0], tdi};
      tck_old_reg  <= tck_sync_reg[1];
    end
  end

  // pin captures and the secondary tap output also cross in through two flops
  reg [1:0]         dbg_tdo_sync_reg;
  reg [BSC_LEN-1:0] pin_meta_reg;
  reg [BSC_LEN-1:0] pin_sync_reg;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_tdo_sync_reg <= 2'h0;
      pin_meta_reg     <= {BSC_LEN{1'b0}};
      pin_sync_reg     <= {BSC_LEN{1'b0}};
    end else begin
      dbg_tdo_sync_reg <= {dbg_tdo_sync_reg[0], dbg_tdo};
      pin_meta_reg     <= bsc_pin_in;
      pin_sync_reg     <= pin_meta_reg;
    end
  end

  // tap controller next state
  reg [3:0] tap_state_reg;
  reg [3:0] tap_state_next;
  always @* begin
    case (tap_state_reg)
      `DASU_TS_RESET:  tap_state_next = tms_s ? `DASU_TS_RESET  : `DASU_TS_IDLE;
      `DASU_TS_IDLE:   tap_state_next = tms_s ? `DASU_TS_SEL_DR : `DASU_TS_IDLE;
      `DASU_TS_SEL_DR: tap_state_next = tms_s ? `DASU_TS_SEL_IR : `DASU_TS_CAP_DR;
      `DASU_TS_CAP_DR: tap_state_next = tms_s ? `DASU_TS_EX1_DR : `DASU_TS_SH_DR;
      `DASU_TS_SH_DR:  tap_state_next = tms_s ? `DASU_TS_EX1_DR : `DASU_TS_SH_DR;
      `DASU_TS_EX1_DR: tap_state_next = tms_s ? `DASU_TS_UPD_DR : `DASU_TS_PAU_DR;
      `DASU_TS_PAU_DR: tap_state_next = tms_s ? `DASU_TS_EX2_DR : `DASU_TS_PAU_DR;
      `DASU_TS_EX2_DR: tap_state_next = tms_s ? `DASU_TS_UPD_DR : `DASU_TS_SH_DR;
      `DASU_TS_UPD_DR: tap_state_next = tms_s ? `DASU_TS_SEL_DR : `DASU_TS_IDLE;
      `DASU_TS_SEL_IR: tap_state_next = tms_s ? `DASU_TS_RESET  : `DASU_TS_CAP_IR;
      `DASU_TS_CAP_IR: tap_state_next = tms_s ? `DASU_TS_EX1_IR : `DASU_TS_SH_IR;
      `DASU_TS_SH_IR:  tap_state_next = tms_s ? `DASU_TS_EX1_IR : `DASU_TS_SH_IR;
      `DASU_TS_EX1_IR: tap_state_next = tms_s ? `DASU_TS_UPD_IR : `DASU_TS_PAU_IR;
      `DASU_TS_PAU_IR: tap_state_next = tms_s ? `DASU_TS_EX2_IR : `DASU_TS_PAU_IR;
      `DASU_TS_EX2_IR: tap_state_next = tms_s ? `DASU_TS_UPD_IR : `DASU_TS_SH_IR;
      `DASU_TS_UPD_IR: tap_state_next = tms_s ? `DASU_TS_SEL_DR : `DASU_TS_IDLE;
      default:         tap_state_next = `DASU_TS_RESET;
    endcase
  end

  // unlock comparison, registered so gating changes one clock later
  reg  [127:0] unlock_scan_register;
  reg          open_reg;
  wire [127:0] merged_code = (otp_visible_code ^ unlock_scan_register) ^ TIE_XOR;
  wire         code_all_zero = ~|otp_visible_code;
  wire         open_next = (merged_code == (FACTORY_CODE ^ TIE_XOR)) & ~code_all_zero;
  assign device_open = open_reg;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      open_reg <= 1'b0;
    else
      open_reg <= open_next;
  end

  // instruction register; blocked instructions fall back to bypass
  reg [3:0] ir_shift_reg;
  reg [3:0] ir_reg;
  reg [3:0] ir_eff;
  always @* begin
    if (open_reg || ir_reg == `DASU_IR_UNLOCK)
      ir_eff = ir_reg;
    else
      ir_eff = `DASU_IR_BYPASS;
  end

  // data registers
  reg               bypass_reg;
  reg [31:0]        id_shift_reg;
  reg [127:0]       ubs_shift_reg;
  reg [BSC_LEN-1:0] bsc_shift_reg;
  reg               ubs_update_pulse;
  wire              sh_dr = tap_state_reg == `DASU_TS_SH_DR;
  wire              sh_ir = tap_state_reg == `DASU_TS_SH_IR;
  wire              bsc_sel = ir_eff == `DASU_IR_EXTEST || ir_eff == `DASU_IR_SAMPLE;
  assign dbg_tap_en = ir_eff == `DASU_IR_DBG_TAP;
  assign dbg_tdi    = tdi_s;

  // tap state, instruction and shift paths advance on tck rise
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_state_reg    <= `DASU_TS_RESET;
      ir_shift_reg     <= 4'h0;
      ir_reg           <= `DASU_IR_IDCODE;
      bypass_reg       <= 1'b0;
      id_shift_reg     <= 32'h00000000;
      ubs_shift_reg    <= 128'h0;
      bsc_shift_reg    <= {BSC_LEN{1'b0}};
      bsc_pin_out      <= {BSC_LEN{1'b0}};
      bsc_drive        <= 1'b0;
      ubs_update_pulse <= 1'b0;
    end else begin
      ubs_update_pulse <= 1'b0;
      if (tck_rise) begin
        tap_state_reg <= tap_state_next;
        case (tap_state_reg)
          `DASU_TS_RESET: begin
            ir_reg    <= `DASU_IR_IDCODE;
            bsc_drive <= 1'b0;
          end
          `DASU_TS_CAP_IR: ir_shift_reg <= `DASU_IR_CAPTURE;
          `DASU_TS_SH_IR:  ir_shift_reg <= {tdi_s, ir_shift_reg[3:1]};
          `DASU_TS_UPD_IR: ir_reg <= ir_shift_reg;
          `DASU_TS_CAP_DR: begin
            bypass_reg <= 1'b0;
            id_shift_reg  <= IDCODE;
            ubs_shift_reg <= 128'h0;
            if (bsc_sel)
              bsc_shift_reg <= pin_sync_reg;
          end
          `DASU_TS_SH_DR: begin
            bypass_reg <= tdi_s;
            if (ir_eff == `DASU_IR_IDCODE)
              id_shift_reg <= {tdi_s, id_shift_reg[31:1]};
            if (ir_eff == `DASU_IR_UNLOCK)
              ubs_shift_reg <= {tdi_s, ubs_shift_reg[127:1]};
            if (bsc_sel)
              bsc_shift_reg <= {tdi_s, bsc_shift_reg[BSC_LEN-1:1]};
          end
          `DASU_TS_UPD_DR: begin
            if (ir_eff == `DASU_IR_UNLOCK)
              ubs_update_pulse <= 1'b1;
            if (bsc_sel)
              bsc_pin_out <= bsc_shift_reg;
            bsc_drive <= ir_eff == `DASU_IR_EXTEST;
          end
          default: ;
        endcase
      end
      if (!open_reg)
        bsc_drive <= 1'b0;
    end
  end

  always @(posedge core_clk or negedge power_on_reset_n) begin
    if (!power_on_reset_n)
      unlock_scan_register <= 128'h0;
    else if (ubs_update_pulse)
      unlock_scan_register <= ubs_shift_reg;
  end

  // test data out changes on tck fall from the selected path
  reg tdo_bit;
  always @* begin
    if (sh_ir)
      tdo_bit = ir_shift_reg[0];
    else
      case (ir_eff)
        `DASU_IR_IDCODE:  tdo_bit = id_shift_reg[0];
        `DASU_IR_UNLOCK:  tdo_bit = ubs_shift_reg[0];
        `DASU_IR_EXTEST:  tdo_bit = bsc_shift_reg[0];
        `DASU_IR_SAMPLE:  tdo_bit = bsc_shift_reg[0];
        `DASU_IR_DBG_TAP: tdo_bit = dbg_tdo_sync_reg[1];
        default:          tdo_bit = bypass_reg;
      endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= tdo_bit;
      tdo_oe <= sh_dr | sh_ir;
    end
  end

  // frame decode and read data, one clock of latency
  wire [9:0] word_idx = bus_addr[11:2];
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    if (rom_frame_select) begin
      case (word_idx)
        `DASU_ROM_IDX_CPU:  rd_word = `DASU_ROM_VAL_CPU;
        `DASU_ROM_IDX_RSV1: rd_word = `DASU_ROM_VAL_RSV1;
        `DASU_ROM_IDX_RSV2: rd_word = `DASU_ROM_VAL_RSV2;
        `DASU_ROM_IDX_RSV3: rd_word = `DASU_ROM_VAL_RSV3;
        `DASU_ROM_IDX_END:  rd_word = `DASU_ROM_VAL_END;
        default:            rd_word = 32'h00000000;
      endcase
    end else if (cpu_debug_frame_select && word_idx == `DASU_CPU_IDX_STATUS) begin
      rd_word[`DASU_STAT_OPEN_BIT] = open_reg;
      rd_word[`DASU_STAT_ZERO_BIT] = code_all_zero;
      rd_word[`DASU_STAT_IR_LSB+3:`DASU_STAT_IR_LSB] = ir_reg;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata  <= 32'h00000000;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_rd & (rom_frame_select | cpu_debug_frame_select);
      bus_rdata  <= bus_rd ? rd_word : 32'h00000000;
    end
  end
endmodule

/* File: tb/dasu_monitor.sv */
`timescale 1ns/1ps
module dasu_monitor #(
  parameter [127:0] FACTORY_CODE = {4{32'hFFFFFFFF}}
) (
  input wire         core_clk,
  input wire         rst_n,
  input wire         power_on_reset_n,
  input wire         rom_frame_select,
  input wire         cpu_debug_frame_select,
  input wire [11:0]  bus_addr,
  input wire         bus_rd,
  input wire [31:0]  bus_rdata,
  input wire         bus_rvalid,
  input wire [127:0] otp_visible_code,
  input wire         dbg_tap_en,
  input wire         bsc_drive,
  input wire         device_open
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // read request into either frame
  wire sel = rom_frame_select | cpu_debug_frame_select;
  wire rom = bus_rd & rom_frame_select & ~cpu_debug_frame_select;
  rd_answer_a: assert property (bus_rd && sel |=> bus_rvalid)
    else $error("selected read not answered");
  no_select_a: assert property (!(bus_rd && sel) |=> !bus_rvalid)
    else $error("answer without selected read");
  rom_word_a: assert property (rom && bus_addr == 12'h004 |=> bus_rdata == 32'h00002002)
    else $error("rom word one wrong");
  rom_hole_a: assert property (rom && bus_addr[11:2] > 10'h004 |=> bus_rdata == 32'h0)
    else $error("rom hole not zero");
  zero_lock_a: assert property ((otp_visible_code == 128'h0) [*2] |-> !device_open)
    else $error("open with all-zero code");
  tap_gate_a: assert property (!device_open |-> !dbg_tap_en)
    else $error("debug tap reachable while secured");
  scan_block_a: assert property (!device_open [*3] |-> !bsc_drive)
    else $error("boundary drive while secured");
  por_eval_a: assert property (!power_on_reset_n [*2] |->
    device_open == (otp_visible_code == FACTORY_CODE && |otp_visible_code))
    else $error("open flag wrong after power-on clear");
endmodule
bind dasu_top dasu_monitor #(.FACTORY_CODE(FACTORY_CODE)) i_mon (
  .core_clk(core_clk), .rst_n(rst_n), .power_on_reset_n(power_on_reset_n),
  .rom_frame_select(rom_frame_select), .cpu_debug_frame_select(cpu_debug_frame_select),
  .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
  .otp_visible_code(otp_visible_code), .dbg_tap_en(dbg_tap_en), .bsc_drive(bsc_drive),
  .device_open(device_open));

/* File: tb/dasu_jtag_host.sv */
`timescale 1ns/1ps
module dasu_jtag_host (
  input  wire clk,
  input  wire tdo,
  output reg  tck,
  output reg  tms,
  output reg  tdi
);
  // clock parked low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 80 ns tck period; tdo taken at the rising edge
  task step(input t, input di, output o);
    begin
      @(negedge clk);
      tms = t;
      tdi = di;
      repeat (7) @(negedge clk);
      o = tdo;
      tck = 1'b1;
      repeat (8) @(negedge clk);
      tck = 1'b0;
    end
  endtask
  // five high tms bits reach test-logic-reset, then idle
  task tap_reset;
    reg o;
    begin
      repeat (5) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
    end
  endtask
  task scan(input is_ir, input integer n, input [127:0] din, output [127:0] dout);
    reg     o;
    integer k;
    begin
      dout = 128'h0;
      step(1'b1, tdi, o);
      if (is_ir) step(1'b1, tdi, o);
      step(1'b0, tdi, o);
      step(1'b0, tdi, o);
      for (k = 0; k < n; k = k + 1) begin
        step(k == n - 1, din[k], o);
        dout[k] = o;
      end
      step(1'b1, tdi, o);
      step(1'b0, tdi, o);
      tdi = ~tdi;  // released line never keeps the last bit
    end
  endtask
endmodule

/* File: tb/debug_access_security_unit_bench.sv */
`timescale 1ns/1ps
module debug_access_security_unit_bench;
  localparam [127:0] FC = {4{32'hFFFFFFFF}};
  localparam [31:0]  ID = 32'h00001001;  // arbitrary identification value
  localparam [191:0] ROMV = {64'h0, 32'h00004003, 32'h00003002, 32'h00002002, 32'h00001003};
  reg         core_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         por_n = 1'b0;
  reg         rom_sel = 1'b0, cpu_sel = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
  reg [11:0]  bus_addr = 12'h000;
  reg [127:0] otp = FC;
  reg [7:0]   pin_in = 8'h3C;
  reg         dbg_tdo_r = 1'b1;
  reg         oe_seen = 1'b0;
  reg [127:0] d;
  wire [31:0] bus_rdata;
  wire [7:0]  pin_out;
  wire        bus_rvalid, tck, tms, tdi, tdo, dbg_tap_en, bsc_drive, device_open;
  wire        tdo_oe, dbg_tdi;
  integer     fail_count = 0, n_compared = 0, i;
  always #2.5 core_clk = ~core_clk;
  // remembers that the output enable rose during a shift
  always @(negedge core_clk)
    if (tdo_oe === 1'b1) oe_seen = 1'b1;
  dasu_top #(.IDCODE(ID), .FACTORY_CODE(FC), .BSC_LEN(8)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .power_on_reset_n(por_n), .rom_frame_select(rom_sel),
    .cpu_debug_frame_select(cpu_sel), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_wdata(32'hA5A5A5A5), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .otp_visible_code(otp), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .dbg_tap_en(dbg_tap_en), .dbg_tdi(dbg_tdi), .dbg_tdo(dbg_tdo_r), .bsc_pin_in(pin_in),
    .bsc_pin_out(pin_out), .bsc_drive(bsc_drive), .device_open(device_open));
  dasu_jtag_host i_host (.clk(core_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  task chk(input string nm, input [127:0] seen, input [127:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one read strobe; answer checked in the following cycle
  task rd(input r, input c, input [11:0] a, input [31:0] e);
    begin
      @(negedge core_clk);
      rom_sel = r;
      cpu_sel = c;
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge core_clk);
      bus_rd = 1'b0;
      rom_sel = 1'b0;
      cpu_sel = 1'b0;
      chk("rvalid", bus_rvalid, r | c);
      if (r | c) chk("rdata", bus_rdata, e);
    end
  endtask
  task settle(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  // table words, holes, ignored write, status
  task t_rom;
    begin
      for (i = 0; i < 6; i = i + 1)
        rd(1'b1, 1'b0, 12'(i * 4), ROMV[i * 32 +: 32]);
      @(negedge core_clk);
      rom_sel = 1'b1;
      bus_wr = 1'b1;
      @(negedge core_clk);
      rom_sel = 1'b0;
      bus_wr = 1'b0;
      rd(1'b1, 1'b0, 12'h004, 32'h00002002);
      rd(1'b0, 1'b1, 12'h010, 32'h0);
      rd(1'b0, 1'b0, 12'h000, 32'h0);
      rd(1'b0, 1'b1, 12'h000, 32'h61);
      $display("rom test done");
    end
  endtask
  task t_id;
    begin
      i_host.tap_reset;
      i_host.scan(1'b0, 32, 128'h0, d);
      chk("idcode", d[31:0], ID);
      chk("oe while shifting", oe_seen, 1'b1);
      settle(4);
      chk("oe idle", tdo_oe, 1'b0);
      i_host.scan(1'b1, 4, 128'h1, d);
      i_host.scan(1'b0, 8, 128'h5A, d);
      chk("sample out", d[7:0], pin_in);
      chk("preload pins", pin_out, 8'h5A);
      chk("sample drive", bsc_drive, 1'b0);
      i_host.scan(1'b1, 4, 128'h0, d);
      chk("ir capture", d[3:0], 4'h1);
      i_host.scan(1'b0, 8, 128'hA5, d);
      chk("boundary out", d[7:0], pin_in);
      chk("pins", pin_out, 8'hA5);
      chk("drive", bsc_drive, 1'b1);
      $display("id and boundary test done");
    end
  endtask
  // secure by clearing one bit, then unlock_scan_register
  task t_lock;
    begin
      otp = FC ^ 128'h20;
      settle(4);
      chk("locked", device_open, 1'b0);
      chk("drive locked", bsc_drive, 1'b0);
      i_host.scan(1'b1, 4, 128'h2, d);
      chk("tap gate", dbg_tap_en, 1'b0);
      i_host.scan(1'b1, 4, 128'h6, d);
      i_host.scan(1'b0, 32, FC, d);
      chk("bypass", d[31:0], 32'hFFFFFFFE);
      i_host.scan(1'b1, 4, 128'hB, d);
      i_host.scan(1'b0, 128, otp ^ FC, d);
      chk("unlocked", device_open, 1'b1);
      i_host.scan(1'b1, 4, 128'h2, d);
      chk("tap open", dbg_tap_en, 1'b1);
      i_host.scan(1'b0, 4, 128'h0, d);
      chk("debug tap out", d[3:0], 4'hF);
      settle(3);
      chk("debug tdi", dbg_tdi, tdi);
      rst_n = 1'b0;
      settle(4);
      rst_n = 1'b1;
      settle(4);
      chk("kept", device_open, 1'b1);
      por_n = 1'b0;
      settle(4);
      por_n = 1'b1;
      settle(4);
      chk("cleared", device_open, 1'b0);
      $display("lock test done");
    end
  endtask
  // all-zero code never opens
  task t_zero;
    begin
      otp = 128'h0;
      i_host.tap_reset;
      i_host.scan(1'b1, 4, 128'hB, d);
      i_host.scan(1'b0, 128, FC, d);
      chk("zero lock", device_open, 1'b0);
      rd(1'b0, 1'b1, 12'h000, 32'hB2);
      otp = FC;
      por_n = 1'b0;
      settle(4);
      por_n = 1'b1;
      settle(4);
      chk("shipped", device_open, 1'b1);
      $display("zero code test done");
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    settle(16);
    rst_n = 1'b1;
    por_n = 1'b1;
    settle(2);
    t_rom;
    t_id;
    t_lock;
    t_zero;
    stop_test;
  end
  // watchdog well beyond the expected run
  initial begin
    #400000;
    fail_count = fail_count + 1;
    stop_test;
  end
endmodule
